// [logic/lfr_fault_readout.v]
// serial-linked channel fault flag words with config, pwm and scan engine
`timescale 1ns/1ps
`include "lfr_map.vh"


module lfr_fault_readout #(
    parameter CHANNELS = `LFR_CHANNELS,
    parameter SCAN_LINES = `LFR_SCAN_LINES,
    parameter PWM_BITS = `LFR_PWM_MAX_BITS
) (
    input wire clk_sys,
    input wire rst,
    input wire serial_clock,
    input wire serial_data_input,
    output reg serial_data_output,
    input wire [CHANNELS-1:0] open_detect,
    input wire [CHANNELS-1:0] short_detect,
    output reg [CHANNELS-1:0] channel_drive,
    output reg [SCAN_LINES-1:0] scan_select,
    output reg grayscale_clock,
    output reg [CHANNELS-1:0] open_load_channel_bits,
    output reg [CHANNELS-1:0] short_channel_bits
);

    // ------------------------------------------------------------------------
    // frame states
    // ------------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CMD = 4'h2;
    localparam [3:0] ST_WDATA = 4'h4;
    localparam [3:0] ST_RDATA = 4'h8;

    localparam [5:0] WORD_LAST = 6'h2F;
    localparam [3:0] CMD_LAST = 4'h7;
    localparam [3:0] RES_FULL = 4'hF;

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    wire sclk_s;
    wire sin_s;
    wire [CHANNELS-1:0] open_s;
    wire [CHANNELS-1:0] short_s;
    reg sclk_d;
    wire sclk_rise;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [3:0] cmd_cnt;
    reg [5:0] bit_cnt;
    reg [`LFR_CMD_BITS-1:0] cmd_shift;
    wire [`LFR_CMD_BITS-1:0] cmd_full;
    reg [`LFR_WORD_BITS-1:0] data_shift;
    reg [`LFR_WORD_BITS-1:0] out_shift;
    reg [5:0] wr_index;
    reg [`LFR_WORD_BITS-1:0] cfg;
    reg clear_req;
    reg [`LFR_WORD_BITS-1:0] snapshot;
    wire [15:0] level;
    wire [3:0] res;
    wire [2:0] mul;
    wire detect_en;
    reg [2:0] burst_cnt;
    reg [PWM_BITS-1:0] pwm_cnt;
    wire [PWM_BITS-1:0] pwm_mask;
    wire pwm_wrap;
    wire pwm_on;

    // ------------------------------------------------------------------------
    // synchronise link pins and detector levels
    // ------------------------------------------------------------------------
    lfr_sync #(
        .W(2)
    ) u_sync_link (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({serial_clock, serial_data_input}),
        .dout({sclk_s, sin_s})
    );

    lfr_sync #(
        .W(2 * CHANNELS)
    ) u_sync_detect (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({open_detect, short_detect}),
        .dout({open_s, short_s})
    );

    // ------------------------------------------------------------------------
    // serial clock edge finder
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d; // data is taken on the rising edge only

    // ------------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------------
    assign level = cfg[`LFR_CFG_LEVEL_MSB:`LFR_CFG_LEVEL_LSB];
    assign res = cfg[`LFR_CFG_RES_MSB:`LFR_CFG_RES_LSB];
    assign mul = cfg[`LFR_CFG_MUL_MSB:`LFR_CFG_MUL_LSB];
    assign detect_en = cfg[`LFR_CFG_DETECT_BIT];
    assign cmd_full = {cmd_shift[`LFR_CMD_BITS-2:0], sin_s};

    // ------------------------------------------------------------------------
    // frame sequencing, one step per serial clock rising edge
    // ------------------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sclk_rise && sin_s) begin
                    next_state = ST_CMD; // a one on an idle line opens a frame
                end
            end
            ST_CMD: begin
                if (sclk_rise && cmd_cnt == CMD_LAST) begin
                    if (cmd_full[`LFR_CMD_READ_BIT]) begin
                        next_state = ST_RDATA;
                    end else if (cmd_full[`LFR_CMD_CLEAR_BIT]) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_WDATA;
                    end
                end
            end
            ST_WDATA: begin
                if (sclk_rise && bit_cnt == WORD_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RDATA: begin
                if (sclk_rise && bit_cnt == WORD_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // command and write data shifting, msb first
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_cnt <= 4'h0;
            bit_cnt <= 6'h00;
            cmd_shift <= {`LFR_CMD_BITS{1'b0}};
            data_shift <= {`LFR_WORD_BITS{1'b0}};
            wr_index <= 6'h00;
        end else if (sclk_rise) begin
            case (state)
                ST_IDLE: begin
                    cmd_cnt <= 4'h0;
                    bit_cnt <= 6'h00;
                end
                ST_CMD: begin
                    cmd_shift <= cmd_full;
                    cmd_cnt <= cmd_cnt + 4'h1;
                    wr_index <= cmd_full[`LFR_CMD_IDX_MSB:0];
                    bit_cnt <= 6'h00;
                end
                ST_WDATA: begin
                    data_shift <= {data_shift[`LFR_WORD_BITS-2:0], sin_s};
                    bit_cnt <= bit_cnt + 6'h01;
                end
                ST_RDATA: begin
                    bit_cnt <= bit_cnt + 6'h01;
                end
                default: begin
                    cmd_cnt <= 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // configuration register write; flag words take no write
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg <= `LFR_CFG_RESET;
        end else if (sclk_rise && state == ST_WDATA && bit_cnt == WORD_LAST) begin
            if (wr_index == `LFR_IDX_CONFIG) begin
                cfg <= {data_shift[`LFR_WORD_BITS-2:0], sin_s};
            end // writes to other indices, flag words among them, are dropped
        end
    end

    // ------------------------------------------------------------------------
    // clear request for the fault flags, one cycle
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_req <= 1'b0;
        end else begin
            clear_req <= sclk_rise && state == ST_CMD && cmd_cnt == CMD_LAST &&
                !cmd_full[`LFR_CMD_READ_BIT] && cmd_full[`LFR_CMD_CLEAR_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // sticky fault flags; a detection in the clear cycle wins
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            open_load_channel_bits <= `LFR_FLAGS_RESET;
            short_channel_bits <= `LFR_FLAGS_RESET;
        end else begin
            open_load_channel_bits <= (clear_req ? {CHANNELS{1'b0}} : open_load_channel_bits) |
                (detect_en ? open_s : {CHANNELS{1'b0}});
            short_channel_bits <= (clear_req ? {CHANNELS{1'b0}} : short_channel_bits) |
                (detect_en ? short_s : {CHANNELS{1'b0}});
        end
    end

    // ------------------------------------------------------------------------
    // read word selection at command accept
    // ------------------------------------------------------------------------
    always @* begin
        case (cmd_full[`LFR_CMD_IDX_MSB:0])
            `LFR_IDX_CONFIG: snapshot = cfg;
            `LFR_IDX_OPEN_FLAGS: snapshot = open_load_channel_bits;
            `LFR_IDX_SHORT_FLAGS: snapshot = short_channel_bits;
            default: snapshot = {`LFR_WORD_BITS{1'b0}};
        endcase
    end

    // ------------------------------------------------------------------------
    // serial output: zero at read accept, then read word msb first, otherwise input passed down the chain
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_shift <= {`LFR_WORD_BITS{1'b0}};
            serial_data_output <= 1'b0;
        end else if (sclk_rise) begin
            if (state == ST_CMD && cmd_cnt == CMD_LAST && cmd_full[`LFR_CMD_READ_BIT]) begin
                out_shift <= snapshot; // whole word frozen as the read is taken
                serial_data_output <= 1'b0;
            end else if (state == ST_RDATA) begin
                serial_data_output <= out_shift[`LFR_WORD_BITS-1];
                out_shift <= {out_shift[`LFR_WORD_BITS-2:0], 1'b0};
            end else begin
                serial_data_output <= sin_s; // one-bit repeat for daisy chaining
            end
        end
    end

    // ------------------------------------------------------------------------
    // grayscale clock: a burst of mul+1 ticks per serial clock rising edge
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            burst_cnt <= 3'h0;
            grayscale_clock <= 1'b0;
        end else if (sclk_rise) begin
            burst_cnt <= mul; // serial clock is the multiplier source
            grayscale_clock <= 1'b1;
        end else if (burst_cnt != 3'h0) begin
            burst_cnt <= burst_cnt - 3'h1;
            grayscale_clock <= 1'b1;
        end else begin
            grayscale_clock <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // pwm counter with selectable resolution up to 16 bits
    // ------------------------------------------------------------------------
    assign pwm_mask = {PWM_BITS{1'b1}} >> (RES_FULL - res);
    assign pwm_wrap = grayscale_clock && (pwm_cnt == pwm_mask);
    assign pwm_on = pwm_cnt < (level & pwm_mask);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_cnt <= {PWM_BITS{1'b0}};
        end else if (pwm_wrap) begin
            pwm_cnt <= {PWM_BITS{1'b0}};
        end else if (grayscale_clock) begin
            pwm_cnt <= (pwm_cnt + 1'b1) & pwm_mask;
        end
    end

    // ------------------------------------------------------------------------
    // scan line rotation on every pwm period
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scan_select <= {{(SCAN_LINES-1){1'b0}}, 1'b1};
        end else if (pwm_wrap) begin
            scan_select <= {scan_select[SCAN_LINES-2:0], scan_select[SCAN_LINES-1]};
        end
    end

    // ------------------------------------------------------------------------
    // channel drive, faulted channels removed
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            channel_drive <= {CHANNELS{1'b0}};
        end else begin
            channel_drive <= {CHANNELS{pwm_on}} & ~open_load_channel_bits & ~short_channel_bits;
        end
    end

endmodule // lfr_fault_readout

// [logic/lfr_map.vh]
// register indices, command encoding, field layout and limits of the fault readout block
`ifndef LFR_MAP_VH
`define LFR_MAP_VH

// ----------------------------------------------------------------------------
// word sizes
// ----------------------------------------------------------------------------
`define LFR_WORD_BITS 48
`define LFR_CHANNELS 48
`define LFR_SCAN_LINES 16
`define LFR_CMD_BITS 8

// ----------------------------------------------------------------------------
// register indices, carried in the low six bits of a command
// ----------------------------------------------------------------------------
`define LFR_IDX_CONFIG 6'h01
`define LFR_IDX_OPEN_FLAGS 6'h14
`define LFR_IDX_SHORT_FLAGS 6'h15

// ----------------------------------------------------------------------------
// command byte: bit 7 read, bit 6 clear fault flags, bits 5..0 index
// ----------------------------------------------------------------------------
`define LFR_CMD_READ_BIT 7
`define LFR_CMD_CLEAR_BIT 6
`define LFR_CMD_IDX_MSB 5

// ----------------------------------------------------------------------------
// configuration word fields and reset values
// ----------------------------------------------------------------------------
`define LFR_CFG_LEVEL_MSB 15
`define LFR_CFG_LEVEL_LSB 0
`define LFR_CFG_RES_MSB 19
`define LFR_CFG_RES_LSB 16
`define LFR_CFG_MUL_MSB 22
`define LFR_CFG_MUL_LSB 20
`define LFR_CFG_DETECT_BIT 23
`define LFR_CFG_RESET 48'h0000_008F_0000
`define LFR_FLAGS_RESET 48'h0000_0000_0000

// ----------------------------------------------------------------------------
// limits of the link and the grayscale engine
// ----------------------------------------------------------------------------
`define LFR_SCLK_MAX_MHZ 50
`define LFR_GRAYSCALE_CLOCK_MAX_MHZ 160
`define LFR_PWM_MAX_BITS 16
`define LFR_CLK_SYS_MHZ 20

`endif

// [logic/lfr_sync.v]
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps

module lfr_sync #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

    reg [W-1:0] meta;

    // ------------------------------------------------------------------------
    // first stage feeds only the second stage
    // ------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule // lfr_sync

// [verification/lfr_ctrl_model.sv]
// display controller model: free-running link clock, frame sender and reply capture
`timescale 1ns/1ps

module lfr_ctrl_model (
    output reg serial_clock,
    output reg serial_data_input,
    input wire serial_data_output
);
    // ------------------------------------------------------------------------
    // link clock, 400 ns period, never paused
    // ------------------------------------------------------------------------
    initial begin
        serial_clock = 1'b0;
        serial_data_input = 1'b0;
        #37;
        forever #200 serial_clock = ~serial_clock;
    end

    // one frame: start bit, command, data; reply bits shifted in one edge late
    task xfer(input [7:0] cmd, input [47:0] wdata, input integer nbits, output reg [47:0] rdata);
        reg [56:0] frame;
        integer i;
        frame = {1'b1, cmd, wdata};
        rdata = 48'h0;
        for (i = 0; i < 58; i = i + 1) begin
            @(negedge serial_clock);
            serial_data_input = (i < nbits) ? frame[56-i] : 1'b0;
            @(posedge serial_clock);
            if (i >= 10) begin
                rdata = {rdata[46:0], serial_data_output};
            end
        end
    endtask
endmodule // lfr_ctrl_model

// [verification/lfr_fault_readout_properties.sv]
// concurrent checks on the ports of the fault readout block
`timescale 1ns/1ps

module lfr_fault_readout_checker #(
    parameter CHANNELS = 48,
    parameter SCAN_LINES = 16,
    parameter PWM_BITS = 16
) (
    input wire clk_sys,
    input wire rst,
    input wire serial_clock,
    input wire serial_data_input,
    input wire serial_data_output,
    input wire [CHANNELS-1:0] open_detect,
    input wire [CHANNELS-1:0] short_detect,
    input wire [CHANNELS-1:0] channel_drive,
    input wire [SCAN_LINES-1:0] scan_select,
    input wire grayscale_clock,
    input wire [CHANNELS-1:0] open_load_channel_bits,
    input wire [CHANNELS-1:0] short_channel_bits
);
    // ------------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------------
    reg sclk_q;
    reg [3:0] since_rise;
    reg [SCAN_LINES-1:0] prev_scan;
    wire [SCAN_LINES-1:0] scan_rotl = {prev_scan[SCAN_LINES-2:0], prev_scan[SCAN_LINES-1]};

    // cycles since the link clock pin was last seen rising, saturating
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            since_rise <= 4'hF;
            prev_scan <= {{(SCAN_LINES-1){1'b0}}, 1'b1};
        end else begin
            sclk_q <= serial_clock;
            prev_scan <= scan_select;
            if (serial_clock && !sclk_q) begin
                since_rise <= 4'h0;
            end else if (since_rise != 4'hF) begin
                since_rise <= since_rise + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    sequence s_link_edge;
        $rose(serial_clock);
    endsequence

    sequence s_tick_seen;
        ##[1:6] grayscale_clock;
    endsequence

    a_grayscale_clock_follows_link: assert property (s_link_edge |-> s_tick_seen)
        else $error("grayscale tick missing after link clock rise");
    a_grayscale_clock_needs_edge: assert property ($rose(grayscale_clock) |-> since_rise <= 4'h6)
        else $error("grayscale tick without link clock rise");
    a_serial_data_output_after_edge: assert property ($changed(serial_data_output) |->
        since_rise >= 4'h1 && since_rise <= 4'h6)
        else $error("serial output moved away from a link clock rise");
    a_open_flag_cause: assert property (((open_load_channel_bits & ~$past(open_load_channel_bits))
        & ~($past(open_detect, 2) | $past(open_detect, 3) | $past(open_detect, 4))) == '0)
        else $error("open flag set without open detector");
    a_short_flag_cause: assert property (((short_channel_bits & ~$past(short_channel_bits))
        & ~($past(short_detect, 2) | $past(short_detect, 3) | $past(short_detect, 4))) == '0)
        else $error("short flag set without short detector");
    a_drive_fault_off: assert property ((channel_drive & ($past(open_load_channel_bits)
        | $past(short_channel_bits))) == '0)
        else $error("faulted channel still driven");
    a_scan_one_hot: assert property ($onehot(scan_select))
        else $error("scan select not one-hot");
    a_scan_rotates: assert property (scan_select != prev_scan |-> scan_select == scan_rotl)
        else $error("scan select moved other than one step left");
endmodule // lfr_fault_readout_checker

// [verification/lfr_tb.sv]
// self-checking bench for the fault readout block
`timescale 1ns/1ps

module tb;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [47:0] open_detect = 48'h0;
    reg [47:0] short_detect = 48'h0;
    reg [47:0] rd;
    wire serial_clock;
    wire serial_data_input;
    wire serial_data_output;
    wire [47:0] channel_drive;
    wire [15:0] scan_select;
    wire grayscale_clock;
    wire [47:0] open_load_channel_bits;
    wire [47:0] short_channel_bits;
    integer n_fail = 0;
    integer checks_done = 0;
    integer cycles = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    lfr_fault_readout dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .serial_clock(serial_clock),
        .serial_data_input(serial_data_input),
        .serial_data_output(serial_data_output),
        .open_detect(open_detect),
        .short_detect(short_detect),
        .channel_drive(channel_drive),
        .scan_select(scan_select),
        .grayscale_clock(grayscale_clock),
        .open_load_channel_bits(open_load_channel_bits),
        .short_channel_bits(short_channel_bits)
    );

    lfr_ctrl_model ctrl (
        .serial_clock(serial_clock),
        .serial_data_input(serial_data_input),
        .serial_data_output(serial_data_output)
    );

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task check48(input [47:0] got, input [47:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // detector levels held for ten cycles, then dropped
    task pulse(input [47:0] o, input [47:0] s);
        @(negedge clk_sys);
        open_detect = o;
        short_detect = s;
        repeat (10) @(negedge clk_sys);
        open_detect = 48'h0;
        short_detect = 48'h0;
        repeat (5) @(negedge clk_sys);
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        check48(open_load_channel_bits, 48'h0);
        check48({32'h0, scan_select}, 48'h0000_0000_0001);
        ctrl.xfer(8'h94, 48'h0, 57, rd);
        check48(rd, 48'h0);
        ctrl.xfer(8'h95, 48'h0, 57, rd);
        check48(rd, 48'h0);
        ctrl.xfer(8'h81, 48'h0, 57, rd);
        check48(rd, 48'h0000_008F_0000);
        // short pwm count so the scan lines rotate
        ctrl.xfer(8'h01, 48'h0000_00F1_0002, 57, rd);
        check48(rd, 48'h0000_00F1_0002);
        ctrl.xfer(8'h81, 48'h0, 57, rd);
        check48(rd, 48'h0000_00F1_0002);
        ctrl.xfer(8'h14, 48'hFFFF_FFFF_FFFF, 57, rd);
        ctrl.xfer(8'h94, 48'h0, 57, rd);
        check48(rd, 48'h0);
        pulse(48'h8000_0000_0001, 48'h0F0F_0000_F0F0);
        check48(open_load_channel_bits, 48'h8000_0000_0001);
        check48(short_channel_bits, 48'h0F0F_0000_F0F0);
        ctrl.xfer(8'h94, 48'h0, 57, rd);
        check48(rd, 48'h8000_0000_0001);
        ctrl.xfer(8'h95, 48'h0, 57, rd);
        check48(rd, 48'h0F0F_0000_F0F0);
        ctrl.xfer(8'hBF, 48'h0, 57, rd);
        check48(rd, 48'h0);
        ctrl.xfer(8'h40, 48'h0, 9, rd);
        ctrl.xfer(8'h94, 48'h0, 57, rd);
        check48(rd, 48'h0);
        check48(short_channel_bits, 48'h0);
        // a flag rising during a read leaves the word taken at command accept
        fork
            ctrl.xfer(8'h94, 48'h0, 57, rd);
            begin
                repeat (100) @(negedge clk_sys);
                pulse(48'h0000_0000_0010, 48'h0);
            end
        join
        check48(rd, 48'h0);
        check48(open_load_channel_bits, 48'h0000_0000_0010);
        // detection switched off: short detector activity leaves the short flags clear
        ctrl.xfer(8'h01, 48'h0000_0071_0002, 57, rd);
        pulse(48'h0, 48'h0000_0000_0100);
        ctrl.xfer(8'h95, 48'h0, 57, rd);
        check48(rd, 48'h0);
        end_of_test;
    end
endmodule // tb

bind lfr_fault_readout lfr_fault_readout_checker #(
    .CHANNELS(CHANNELS),
    .SCAN_LINES(SCAN_LINES),
    .PWM_BITS(PWM_BITS)
) chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .serial_clock(serial_clock),
    .serial_data_input(serial_data_input),
    .serial_data_output(serial_data_output),
    .open_detect(open_detect),
    .short_detect(short_detect),
    .channel_drive(channel_drive),
    .scan_select(scan_select),
    .grayscale_clock(grayscale_clock),
    .open_load_channel_bits(open_load_channel_bits),
    .short_channel_bits(short_channel_bits)
);
